// ==== logic/close_latch_supervision.sv ====
// close command latch with reclose supervision, APB slave for settings
// assumes condition inputs are asynchronous levels; APB on the block clock
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps

module close_latch_supervision #(
   parameter int unsigned INTERVAL_CYCLES = recloser_close_pkg::INTERVAL_CYCLES // per interval
) (
   input wire logic clk,                        // 250 MHz block clock
   input wire logic srst,                       // synchronous reset, active high
   input wire logic psel,                       // APB select
   input wire logic penable,                    // APB access phase
   input wire logic pwrite,                     // APB direction, high for write
   input wire logic [7:0] paddr,                // APB byte address
   input wire logic [31:0] pwdata,              // APB write data
   output logic [31:0] prdata,                  // APB read data
   output logic pready,                         // APB ready
   output logic pslverr,                        // APB error, unmapped address
   input wire logic breakerStatusRaw,           // auxiliary contact level
   input wire logic manualCloseRequest,         // close request other than reclosing
   input wire logic closeUnlatchCond,           // extra unlatch condition
   input wire logic recloseInitiate,            // reclose initiation level
   input wire logic openIntervalTimeout,        // sequencer open interval time-out
   input wire logic sequencerLockoutState,      // sequencer in lockout
   input wire logic recloseSupervisionCond,     // supervision condition
   output logic closeCmd,                       // latched close command
   output logic closeOutputDriver,              // close output transistor drive
   output logic closeFailFlag,                  // close failure, one interval
   output logic supervisionFailPulse,           // supervision failure, one interval
   output logic lockoutRequest,                 // drive sequencer to lockout
   output logic breakerClosedStatus             // evaluated breaker status bit
);
   typedef struct packed {
      logic [recloser_close_pkg::NUM_IN-1:0] sync1;
      logic [recloser_close_pkg::NUM_IN-1:0] sync2;
      logic [20:0] divCount;
      logic tick;
      logic close;
      logic closeOut;
      logic failFlag;
      logic supFail;
      logic lockReq;
      logic breakerBit;
      logic sealed;
      logic routeClose;
      logic defeat;
      logic invert;
      logic [15:0] failTime;
      logic [15:0] winTime;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } state_t;

   state_t state;
   state_t next_state;

   logic breakerEval;
   logic unlatchLvl;
   logic timeoutLvl;
   logic lockoutLvl;
   logic superviseLvl;
   logic riRise;
   logic manRise;
   logic [1:0] riseVec;
   logic cfExpired;
   logic winExpired;
   logic winZero;
   logic setAllowed;
   logic sealSetOk;
   logic sealNow;
   logic sealClear;
   logic passTimeout;
   logic failNow;
   logic [31:0] statusWord;

   interval_timer_if cfBus();
   interval_timer_if winBus();

   // only the second sync stage is read below
   assign unlatchLvl = state.sync2[recloser_close_pkg::IN_UNLATCH];
   assign timeoutLvl = state.sync2[recloser_close_pkg::IN_TIMEOUT];
   assign lockoutLvl = state.sync2[recloser_close_pkg::IN_LOCKOUT];
   assign superviseLvl = state.sync2[recloser_close_pkg::IN_SUPERVISE];
   // defeat forces the status to zero, invert serves a b-type contact
   assign breakerEval = !state.defeat
      && (state.sync2[recloser_close_pkg::IN_BREAKER] ^ state.invert);

   rise_detect #(
      .WIDTH(2)
   ) u_rise (
      .clk(clk),
      .srst(srst),
      .tick(state.tick),
      .din({state.sync2[recloser_close_pkg::IN_INITIATE],
            state.sync2[recloser_close_pkg::IN_MANUAL]}),
      .rise(riseVec)
   );
   assign manRise = riseVec[0];
   assign riRise = riseVec[1];

   // close failure timer runs while the command stands
   assign cfBus.run = state.close;
   assign cfBus.limit = state.failTime;
   assign cfExpired = cfBus.expired;
   interval_timer u_cf_timer (
      .clk(clk),
      .srst(srst),
      .tick(state.tick),
      .tmr(cfBus)
   );

   // supervision window timer runs while a time-out is sealed
   assign winBus.run = state.sealed;
   assign winBus.limit = state.winTime;
   assign winExpired = winBus.expired;
   interval_timer u_win_timer (
      .clk(clk),
      .srst(srst),
      .tick(state.tick),
      .tmr(winBus)
   );

   // permissives and supervision decisions
   assign winZero = (state.winTime == 16'h0000);
   assign setAllowed = !unlatchLvl && !breakerEval && !riRise
      && !state.failFlag && !cfExpired && !state.defeat;
   assign sealSetOk = !state.close && !lockoutLvl && !breakerEval
      && !riRise && !state.supFail;
   assign sealNow = !winZero && (state.sealed || (timeoutLvl && sealSetOk));
   assign sealClear = state.close || lockoutLvl || breakerEval || riRise
      || superviseLvl || winExpired;
   assign passTimeout = superviseLvl
      && ((winZero && timeoutLvl) || sealNow);
   assign failNow = (winZero && timeoutLvl && !superviseLvl)
      || (state.sealed && winExpired && !superviseLvl);

   assign statusWord = {26'h0000000, lockoutLvl, state.supFail, state.breakerBit,
                        state.sealed, state.failFlag, state.close};

   // one evaluation of the interval logic per tick, APB every clock
   always_comb
   begin
      next_state = state;
      next_state.sync1 = {recloseSupervisionCond, sequencerLockoutState,
                          openIntervalTimeout, recloseInitiate, closeUnlatchCond,
                          manualCloseRequest, breakerStatusRaw};
      next_state.sync2 = state.sync1;
      next_state.breakerBit = breakerEval;
      if (state.divCount == 21'(INTERVAL_CYCLES - 1))
      begin
         next_state.divCount = 21'h000000;
         next_state.tick = 1'b1;
      end
      else
      begin
         next_state.divCount = state.divCount + 21'h000001;
         next_state.tick = 1'b0;
      end
      if (state.tick)
      begin
         next_state.close = (setAllowed && (passTimeout || manRise))
            || (state.close && !(unlatchLvl || breakerEval || riRise
                                 || cfExpired || state.defeat));
         next_state.failFlag = cfExpired;
         next_state.supFail = failNow;
         next_state.lockReq = failNow;
         next_state.sealed = sealNow && !sealClear;
      end
      next_state.closeOut = state.routeClose && next_state.close;
      // registered answer: ready one cycle after setup, never later
      next_state.pready = 1'b0;
      next_state.pslverr = 1'b0;
      next_state.prdata = 32'h00000000;
      if (psel && !penable)
      begin
         next_state.pready = 1'b1;
         if (paddr == recloser_close_pkg::CTRL_OFS)
            next_state.prdata = {29'h00000000, state.invert, state.defeat, state.routeClose};
         else if (paddr == recloser_close_pkg::CLOSE_FAIL_TIME_OFS)
            next_state.prdata = {16'h0000, state.failTime};
         else if (paddr == recloser_close_pkg::WINDOW_TIME_OFS)
            next_state.prdata = {16'h0000, state.winTime};
         else if (paddr == recloser_close_pkg::STATUS_OFS)
            next_state.prdata = statusWord;
         else
            next_state.pslverr = 1'b1;
      end
      // writes land only at the completing edge; status is read only
      if (psel && penable && state.pready && pwrite && !state.pslverr)
      begin
         if (paddr == recloser_close_pkg::CTRL_OFS)
         begin
            next_state.routeClose = pwdata[recloser_close_pkg::CTRL_ROUTE_BIT];
            next_state.defeat = pwdata[recloser_close_pkg::CTRL_DEFEAT_BIT];
            next_state.invert = pwdata[recloser_close_pkg::CTRL_INVERT_BIT];
         end
         else if (paddr == recloser_close_pkg::CLOSE_FAIL_TIME_OFS)
            next_state.failTime = pwdata[15:0];
         else if (paddr == recloser_close_pkg::WINDOW_TIME_OFS)
            next_state.winTime = pwdata[15:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state <= '0;
         state.routeClose <= recloser_close_pkg::CTRL_ROUTE_RST;
         state.defeat <= recloser_close_pkg::CTRL_DEFEAT_RST;
         state.invert <= recloser_close_pkg::CTRL_INVERT_RST;
         state.failTime <= recloser_close_pkg::CLOSE_FAIL_TIME_RST;
         state.winTime <= recloser_close_pkg::WINDOW_TIME_RST;
      end
      else
         state <= next_state;
   end

   // outputs straight from the state flops
   assign closeCmd = state.close;
   assign closeOutputDriver = state.closeOut;
   assign closeFailFlag = state.failFlag;
   assign supervisionFailPulse = state.supFail;
   assign lockoutRequest = state.lockReq;
   assign breakerClosedStatus = state.breakerBit;
   assign prdata = state.prdata;
   assign pready = state.pready;
   assign pslverr = state.pslverr;

   // checks on the interval logic
   property p_setBlocked;
      @(posedge clk) disable iff (srst)
      state.tick && !state.close && (unlatchLvl || breakerEval || riRise) |=> !closeCmd;
   endproperty
   a_setBlocked: assert property (p_setBlocked) else $error("close set while blocked");

   property p_manualSets;
      @(posedge clk) disable iff (srst)
      state.tick && setAllowed && manRise |=> closeCmd ##1 closeOutputDriver || !state.routeClose;
   endproperty
   a_manualSets: assert property (p_manualSets) else $error("manual edge did not close");

   property p_unlatch;
      @(posedge clk) disable iff (srst)
      closeCmd && state.tick && (unlatchLvl || breakerEval || riRise) |=> !closeCmd;
   endproperty
   a_unlatch: assert property (p_unlatch) else $error("close did not unlatch");

   property p_holdBetweenTicks;
      @(posedge clk) disable iff (srst)
      closeCmd && !state.tick |=> closeCmd;
   endproperty
   a_holdBetweenTicks: assert property (p_holdBetweenTicks) else $error("close lost");

   property p_failDrops;
      @(posedge clk) disable iff (srst)
      $rose(closeFailFlag) |-> !closeCmd ##1 !closeCmd;
   endproperty
   a_failDrops: assert property (p_failDrops) else $error("failure did not drop close");

   property p_failOff;
      @(posedge clk) disable iff (srst)
      state.failTime == recloser_close_pkg::TIME_OFF && !state.failFlag |=> !closeFailFlag;
   endproperty
   a_failOff: assert property (p_failOff) else $error("failure with timer off");

   property p_defeat;
      @(posedge clk) disable iff (srst)
      state.defeat && state.tick |=> !closeCmd && !breakerClosedStatus;
   endproperty
   a_defeat: assert property (p_defeat) else $error("close while defeated");

   property p_route;
      @(posedge clk) disable iff (srst)
      state.routeClose && $past(state.routeClose) |-> closeOutputDriver == closeCmd;
   endproperty
   a_route: assert property (p_route) else $error("close output not following");

   property p_zeroFail;
      @(posedge clk) disable iff (srst)
      state.tick && winZero && timeoutLvl && !superviseLvl && !closeCmd && !manRise
         |=> supervisionFailPulse && lockoutRequest && !closeCmd;
   endproperty
   a_zeroFail: assert property (p_zeroFail) else $error("zero window failure missed");

   property p_zeroPass;
      @(posedge clk) disable iff (srst)
      state.tick && winZero && timeoutLvl && superviseLvl && setAllowed |=> closeCmd;
   endproperty
   a_zeroPass: assert property (p_zeroPass) else $error("zero window pass missed");

   property p_sealPass;
      @(posedge clk) disable iff (srst)
      state.tick && !winZero && state.sealed && superviseLvl && setAllowed
         |=> closeCmd && !state.sealed;
   endproperty
   a_sealPass: assert property (p_sealPass) else $error("sealed time-out not passed");

   property p_sealClear;
      @(posedge clk) disable iff (srst)
      state.tick && state.sealed && sealClear |=> !state.sealed;
   endproperty
   a_sealClear: assert property (p_sealClear) else $error("seal not cleared");

   property p_pulseOne;
      @(posedge clk) disable iff (srst)
      supervisionFailPulse && state.tick && !failNow |=> !supervisionFailPulse;
   endproperty
   a_pulseOne: assert property (p_pulseOne) else $error("failure pulse too long");

   property p_sealBlocked;
      @(posedge clk) disable iff (srst)
      state.tick && !state.sealed && (closeCmd || lockoutLvl || breakerEval || riRise
         || supervisionFailPulse) |=> !state.sealed;
   endproperty
   a_sealBlocked: assert property (p_sealBlocked) else $error("seal set while blocked");

   property p_windowOff;
      @(posedge clk) disable iff (srst)
      state.tick && state.sealed && state.winTime == recloser_close_pkg::TIME_OFF
         |=> !supervisionFailPulse;
   endproperty
   a_windowOff: assert property (p_windowOff) else $error("failure with window off");

   property p_statusBit;
      @(posedge clk) disable iff (srst)
      breakerClosedStatus == $past(breakerEval);
   endproperty
   a_statusBit: assert property (p_statusBit) else $error("status bit not following");
endmodule : close_latch_supervision

// ==== logic/interval_timer.sv ====
// interval timer counting processing intervals while its run input stands
// assumes tick is a one-clock pulse once per processing interval
`timescale 1ns/100ps
module interval_timer (
   input wire logic clk,                  // block clock
   input wire logic srst,                 // synchronous reset, active high
   input wire logic tick,                 // processing interval strobe
   interval_timer_if.timer tmr            // run, limit and expiry
);
   typedef struct packed {
      logic [15:0] count;
   } state_t;

   state_t state;
   state_t next_state;

   // expiry is seen in the interval that completes the limit
   assign tmr.expired = tmr.run && (tmr.limit != recloser_close_pkg::TIME_OFF)
      && (({1'b0, state.count} + 17'h00001) >= {1'b0, tmr.limit});

   // count only on ticks; saturates at expiry, but wraps when the limit is all ones and no expiry comes
   always_comb
   begin
      next_state = state;
      if (!tmr.run)
         next_state.count = 16'h0000;
      else if (tick && !tmr.expired)
         next_state.count = state.count + 16'h0001;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         state <= '0;
      else
         state <= next_state;
   end
endmodule : interval_timer

// ==== logic/interval_timer_if.sv ====
// carrier between the supervising logic and one interval timer
// assumes both ends share the block clock
`timescale 1ns/100ps
interface interval_timer_if;
   logic run;            // timing while high, cleared while low
   logic [15:0] limit;   // intervals to expiry, all ones disables
   logic expired;        // limit reached while running

   modport timer (input run, input limit, output expired);
   modport user (output run, output limit, input expired);
endinterface : interval_timer_if

// ==== logic/recloser_close_pkg.sv ====
// constants for the close latch and reclose supervision block
// assumes a 250 MHz clock and settings expressed in quarter power cycles
package recloser_close_pkg;
   // clock and processing interval (quarter of a 60 Hz power cycle)
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned INTERVAL_NS = 4166667;
   localparam int unsigned INTERVAL_CYCLES = INTERVAL_NS / CLK_PERIOD_NS;
   localparam int unsigned INTERVALS_PER_CYCLE = 4;

   // timer settings, in processing intervals
   localparam logic [15:0] TIME_OFF = 16'hffff;
   localparam logic [15:0] CLOSE_FAIL_TIME_RST = 16'h00f0; // 60.00 cycles
   localparam logic [15:0] WINDOW_TIME_RST = 16'h0000;     // 0.00: single check

   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CLOSE_FAIL_TIME_OFS = 8'h04;
   localparam logic [7:0] WINDOW_TIME_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;

   // control register fields and reset values
   localparam int CTRL_ROUTE_BIT = 0;
   localparam int CTRL_DEFEAT_BIT = 1;
   localparam int CTRL_INVERT_BIT = 2;
   localparam logic CTRL_ROUTE_RST = 1'b1;
   localparam logic CTRL_DEFEAT_RST = 1'b0;
   localparam logic CTRL_INVERT_RST = 1'b0;

   // status register fields
   localparam int STAT_CLOSE_BIT = 0;
   localparam int STAT_FAIL_BIT = 1;
   localparam int STAT_SEALED_BIT = 2;
   localparam int STAT_BREAKER_BIT = 3;
   localparam int STAT_SUPFAIL_BIT = 4;
   localparam int STAT_LOCKOUT_BIT = 5;

   // positions of the synchronised condition inputs
   localparam int NUM_IN = 7;
   localparam int IN_BREAKER = 0;
   localparam int IN_MANUAL = 1;
   localparam int IN_UNLATCH = 2;
   localparam int IN_INITIATE = 3;
   localparam int IN_TIMEOUT = 4;
   localparam int IN_LOCKOUT = 5;
   localparam int IN_SUPERVISE = 6;
endpackage : recloser_close_pkg

// ==== logic/rise_detect.sv ====
// rising edge detector sampled once per processing interval
// assumes din is already in the clock domain
`timescale 1ns/100ps
module rise_detect #(
   parameter int WIDTH = 2                // number of inputs
) (
   input wire logic clk,                  // block clock
   input wire logic srst,                 // synchronous reset, active high
   input wire logic tick,                 // processing interval strobe
   input wire logic [WIDTH-1:0] din,      // levels to watch
   output logic [WIDTH-1:0] rise          // valid in the tick cycle
);
   typedef struct packed {
      logic [WIDTH-1:0] prev;
   } state_t;

   state_t state;
   state_t next_state;

   // compare against last interval, not last clock
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         assign rise[i] = din[i] && !state.prev[i];
      end
   endgenerate

   always_comb
   begin
      next_state = state;
      if (tick)
         next_state.prev = din;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         state <= '0;
      else
         state <= next_state;
   end
endmodule : rise_detect

// ==== test/breaker_model.sv ====
// breaker auxiliary contact that answers the close output
// assumes close drive, trip and stuck are levels on the block clock
`timescale 1ns/100ps
module breaker_model #(
   parameter int CLOSE_LAT = 24   // clocks of close drive before the contact makes
) (
   input wire logic clk,          // block clock
   input wire logic closeDrive,   // close output from the design
   input wire logic trip,         // bench request to open the breaker
   input wire logic stuck,        // jammed mechanism, never closes
   output logic contact           // a-type auxiliary contact level
);
   int held = 0;
   logic made = 1'b0;
   assign contact = made;
   // contact makes only after a sustained drive, so a short glitch never closes it
   always @(posedge clk)
   begin
      held <= closeDrive ? held + 1 : 0;
      if (trip)
         made <= 1'b0;
      else if (!stuck && held >= CLOSE_LAT)
         made <= 1'b1;
   end
endmodule : breaker_model

// ==== test/close_latch_supervision_bench.sv ====
// self-checking bench for the close latch and reclose supervision block
// assumes an interval of 8 clocks; outputs are read at rising edges, before they update
`timescale 1ns/100ps
module close_latch_supervision_bench;
   localparam int IV = 8;
   localparam int LIMIT = 20000;
   localparam logic [7:0] A_CTRL = recloser_close_pkg::CTRL_OFS;
   localparam logic [7:0] A_FAIL = recloser_close_pkg::CLOSE_FAIL_TIME_OFS;
   localparam logic [7:0] A_WIN = recloser_close_pkg::WINDOW_TIME_OFS;
   localparam logic [7:0] A_STAT = recloser_close_pkg::STATUS_OFS;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic manual = 1'b0;
   logic unlatch = 1'b0;
   logic initiate = 1'b0;
   logic timeout = 1'b0;
   logic lockIn = 1'b0;
   logic supervise = 1'b0;
   logic trip = 1'b0;
   logic stuck = 1'b0;
   logic breakerRaw;
   logic closeCmd;
   logic closeDrv;
   logic failFlag;
   logic supFail;
   logic lockReq;
   logic brkStatus;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   int t0;
   int t1;
   int len;

   close_latch_supervision #(
      .INTERVAL_CYCLES(IV)
   ) close_latch_supervision_i (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .breakerStatusRaw(breakerRaw), .manualCloseRequest(manual),
      .closeUnlatchCond(unlatch), .recloseInitiate(initiate),
      .openIntervalTimeout(timeout), .sequencerLockoutState(lockIn),
      .recloseSupervisionCond(supervise), .closeCmd(closeCmd),
      .closeOutputDriver(closeDrv), .closeFailFlag(failFlag),
      .supervisionFailPulse(supFail), .lockoutRequest(lockReq),
      .breakerClosedStatus(brkStatus)
   );

   breaker_model breaker_model_i (
      .clk(clk), .closeDrive(closeDrv), .trip(trip), .stuck(stuck), .contact(breakerRaw)
   );

   // 250 MHz clock
   always #2 clk = ~clk;

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   // hang guard, far above the thousand or so cycles the tests need
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == LIMIT)
      begin
         err_total = err_total + 1;
         summarize();
      end
   end

   task automatic chkBit(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value %s expected %b seen %b", nm, e, g);
      end
   endtask : chkBit

   task automatic chkWord(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chkWord

   task automatic iv(input int n);
      repeat (n * IV) @(posedge clk);
   endtask : iv

   // request held until ready is seen at a rising edge; answer taken at that edge
   // no wait limit of its own: the hang guard ends a stuck transfer
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdChk(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h00000000, q, e);
      chkWord("read data", x, q);
      chkBit("slave error", xe, e);
   endtask : rdChk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
      chkBit("slave error", 1'b0, e);
   endtask : wr

   function automatic logic pick(input int s);
      case (s)
         0: return closeCmd;
         1: return failFlag;
         default: return supFail;
      endcase
   endfunction : pick

   // bounded wait for a rise, stamped in clock cycles
   task automatic waitRise(input int s, input int lim, output int t);
      int n;
      n = 0;
      @(posedge clk);
      while (pick(s) !== 1'b1 && n < lim)
      begin
         @(posedge clk);
         n++;
      end
      t = cyc;
      chkBit("rise seen", 1'b1, pick(s));
   endtask : waitRise

   task automatic hiLen(input int s, output int l);
      l = 0;
      while (pick(s) === 1'b1 && l < 4 * IV)
      begin
         @(posedge clk);
         l++;
      end
   endtask : hiLen

   // sequencer time-out lasts exactly one interval, so one tick sees it
   task automatic pulseTimeout();
      timeout <= 1'b1;
      repeat (IV) @(posedge clk);
      timeout <= 1'b0;
   endtask : pulseTimeout

   task automatic failWatch(input int lim, output int t, output int l);
      waitRise(2, lim, t);
      chkBit("lockout request", 1'b1, lockReq);
      hiLen(2, l);
   endtask : failWatch

   task automatic clearByInitiate();
      initiate <= 1'b1;
      iv(3);
      chkBit("close", 1'b0, closeCmd);
      initiate <= 1'b0;
      supervise <= 1'b0;
      iv(2);
   endtask : clearByInitiate

   initial
   begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      rdChk(A_CTRL, 32'h00000001, 1'b0);
      rdChk(A_FAIL, 32'h000000f0, 1'b0);
      rdChk(A_WIN, 32'h00000000, 1'b0);
      rdChk(8'h10, 32'h00000000, 1'b1);
      wr(A_FAIL, 32'h00000008);
      // manual close, breaker makes and unlatches it
      manual <= 1'b1;
      iv(2);
      chkBit("close", 1'b1, closeCmd);
      chkBit("close output", 1'b1, closeDrv);
      iv(5);
      chkBit("close", 1'b0, closeCmd);
      chkBit("breaker status", 1'b1, brkStatus);
      manual <= 1'b0;
      trip <= 1'b1;
      stuck <= 1'b1;
      iv(3);
      trip <= 1'b0;
      // jammed breaker, failure timer drops the close
      manual <= 1'b1;
      waitRise(0, 3 * IV, t0);
      waitRise(1, 12 * IV, t1);
      chkWord("fail delay", 8 * IV, t1 - t0);
      chkBit("close", 1'b0, closeCmd);
      hiLen(1, len);
      chkWord("fail width", IV, len);
      manual <= 1'b0;
      iv(2);
      wr(A_FAIL, 32'h0000ffff);
      manual <= 1'b1;
      iv(14);
      chkBit("close", 1'b1, closeCmd);
      unlatch <= 1'b1;
      iv(3);
      chkBit("close", 1'b0, closeCmd);
      manual <= 1'b0;
      iv(2);
      manual <= 1'b1;
      iv(3);
      chkBit("close", 1'b0, closeCmd);
      unlatch <= 1'b0;
      manual <= 1'b0;
      iv(2);
      // defeat, then inverted contact, then output routing off
      wr(A_CTRL, 32'h00000003);
      manual <= 1'b1;
      iv(3);
      chkBit("close", 1'b0, closeCmd);
      manual <= 1'b0;
      wr(A_CTRL, 32'h00000007);
      iv(2);
      chkBit("breaker status", 1'b0, brkStatus);
      wr(A_CTRL, 32'h00000005);
      iv(2);
      chkBit("breaker status", 1'b1, brkStatus);
      wr(A_CTRL, 32'h00000000);
      manual <= 1'b1;
      iv(3);
      chkBit("close", 1'b1, closeCmd);
      chkBit("close output", 1'b0, closeDrv);
      clearByInitiate();
      manual <= 1'b0;
      wr(A_CTRL, 32'h00000001);
      // zero window: single check at time-out
      supervise <= 1'b1;
      pulseTimeout();
      iv(2);
      chkBit("close", 1'b1, closeCmd);
      clearByInitiate();
      fork
         pulseTimeout();
         failWatch(3 * IV, t1, len);
      join
      chkWord("supervision fail width", IV, len);
      chkBit("close", 1'b0, closeCmd);
      // nonzero window
      wr(A_WIN, 32'h00000006);
      pulseTimeout();
      iv(3);
      supervise <= 1'b1;
      iv(2);
      chkBit("close", 1'b1, closeCmd);
      chkBit("supervision fail", 1'b0, supFail);
      clearByInitiate();
      t0 = cyc;
      fork
         pulseTimeout();
         failWatch(10 * IV, t1, len);
      join
      chkBit("window length", 1'b1, (t1 - t0 >= 6 * IV) && (t1 - t0 <= 7 * IV + 4));
      chkWord("supervision fail width", IV, len);
      // lockout keeps a time-out from sealing
      lockIn <= 1'b1;
      pulseTimeout();
      supervise <= 1'b1;
      iv(3);
      chkBit("close", 1'b0, closeCmd);
      lockIn <= 1'b0;
      supervise <= 1'b0;
      iv(8);
      // window off: the seal waits without limit
      wr(A_WIN, 32'h0000ffff);
      pulseTimeout();
      iv(20);
      rdChk(A_STAT, 32'h00000001 << recloser_close_pkg::STAT_SEALED_BIT, 1'b0);
      supervise <= 1'b1;
      iv(2);
      chkBit("close", 1'b1, closeCmd);
      clearByInitiate();
      rdChk(A_STAT, 32'h00000000, 1'b0);
      summarize();
   end
endmodule : close_latch_supervision_bench
